// file: core/line_buffer_pkg.sv
// Constants, carriers and state layout of the line buffer and miss timing
package line_buffer_pkg;
  localparam int ENTRIES = 4;
  localparam int RANK_W = 2;
  localparam int LINE_BITS = 128;
  localparam int LINE_BYTES = 16;
  localparam int ADDR_W = 32;
  localparam int WORD_W = 32;
  localparam int WORD_BYTES = 4;
  localparam int LINE_LSB = 4;
  localparam int WORD_LSB = 2;
  localparam int WORD_SEL_W = 2;
  localparam int TAG_W = ADDR_W - LINE_LSB;
  localparam int LAT_W = 10;
  localparam int AGE_W = 8;
  localparam int REGION_MSB = 31;
  localparam int REGION_LSB = 28;
  localparam logic [3:0] REGION_NVS = 4'h0;
  localparam logic [3:0] REGION_XSRAM = 4'h1;
  localparam logic [3:0] REGION_SERIAL = 4'h2;
  // Unloaded miss figures in cycles
  localparam logic [LAT_W-1:0] LAT_XSRAM_LP = 10'h00A;
  localparam logic [LAT_W-1:0] LAT_XSRAM_HP = 10'h013;
  localparam logic [LAT_W-1:0] LAT_NVS_LP = 10'h00B;
  localparam logic [LAT_W-1:0] LAT_NVS_HP = 10'h015;
  localparam logic [LAT_W-1:0] LAT_SER_LP_MIN = 10'h027;
  localparam logic [LAT_W-1:0] LAT_SER_LP_MAX = 10'h02D;
  localparam logic [LAT_W-1:0] LAT_SER_HP_MIN = 10'h04D;
  localparam logic [LAT_W-1:0] LAT_SER_HP_MAX = 10'h059;
  localparam logic [LAT_W-1:0] LAT_PIPE = 10'h002;
  localparam logic [AGE_W-1:0] FLUSH_AGE_DEFAULT = 8'h40;
  localparam logic [ENTRIES-1:0][RANK_W-1:0] RANK_INIT =
    {2'h3, 2'h2, 2'h1, 2'h0};

  typedef struct packed {
    logic valid;
    logic write;
    logic instr;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
    logic [WORD_BYTES-1:0] be;
  } cpu_req_t;

  typedef struct packed {
    logic strobe_capture;
    logic [3:0] turnaround;
    logic [7:0] bus_latency;
  } serial_cfg_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [LINE_BITS-1:0] wdata;
    logic [LINE_BYTES-1:0] be;
  } mem_cmd_t;

  typedef struct packed {
    logic valid;
    logic dirty;
    logic [TAG_W-1:0] tag;
    logic [LINE_BYTES-1:0] bv;
    logic [LINE_BITS-1:0] data;
    logic [AGE_W-1:0] age;
  } entry_t;

  typedef struct packed {
    logic valid;
    logic [TAG_W-1:0] tag;
    logic [LINE_BYTES-1:0] bv;
    logic [LINE_BITS-1:0] data;
  } evict_t;

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_WAIT} fsm_t;

  typedef struct packed {
    fsm_t fsm;
    entry_t [ENTRIES-1:0] ent;
    logic [ENTRIES-1:0][RANK_W-1:0] rank;
    evict_t ev;
    logic [LAT_W-1:0] cnt;
    logic [LAT_W-1:0] lat;
    logic [LAT_W-1:0] wcnt;
    logic [ADDR_W-1:0] maddr;
    logic [RANK_W-1:0] midx;
    logic rsp_valid;
    logic [WORD_W-1:0] rsp_data;
    logic flush_pend;
  } state_t;
endpackage

// file: core/memory_line_buffer_latency.sv
// Write-merging line buffer with per-memory miss timing
// Functional notes
// RL1 - Four 128-bit line entries, LRU allocated
// RL2 - Narrow writes merge into matching entry
// RL3 - Flush on age, eviction or command
// RL4 - Slot-available writes and hits: zero waits
// RL5 - No slot: stall by bus load only
// RL6 - Hits from buffer; misses return critical word
// RL7 - Extended SRAM miss: 10 or 19
// RL8 - Serial data miss: 39-45 or 77-89
// RL9 - Execute-in-place adds serial bus latency
// RL10 - Serial data timing same as instruction
// RL11 - Strobe capture, turnaround vary serial waits
// RL12 - Nonvolatile miss: 11 or 21 cycles
// RL13 - Misses fetch line from backing store
// RL14 - Evicted data written before entry reuse
// RL15 - Extra waits only from bus contention
`timescale 1ns/100ps
module memory_line_buffer_latency import line_buffer_pkg::*; #(
  parameter logic [AGE_W-1:0] FLUSH_AGE = FLUSH_AGE_DEFAULT
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Core request and response
  input wire cpu_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [WORD_W-1:0] rsp_data,
  // Operating mode and buffer control
  input wire logic high_performance_operating_mode,
  input wire logic flush_cmd,
  output logic flush_busy,
  // Serial memory port timing
  input wire serial_cfg_t multibit_serial_memory_port_cfg,
  // System bus
  output mem_cmd_t mem_cmd,
  input wire logic mem_gnt,
  input wire logic [LINE_BITS-1:0] mem_rdata
);

  state_t s;
  state_t next_s;
  logic [ENTRIES-1:0] tag_hit;
  logic hit;
  logic word_ok;
  logic [RANK_W-1:0] hidx;
  logic [RANK_W-1:0] vic;
  logic [LAT_W-1:0] lat;
  logic [WORD_SEL_W-1:0] wsel;
  logic [3:0] region;

  assign wsel = req.addr[LINE_LSB-1:WORD_LSB];
  assign region = req.addr[REGION_MSB:REGION_LSB];

  genvar gi;
  generate
    for (gi = 0; gi < ENTRIES; gi++) begin : g_match
      assign tag_hit[gi] = s.ent[gi].valid &&
        s.ent[gi].tag == req.addr[ADDR_W-1:LINE_LSB];
    end
  endgenerate

  function automatic logic [ENTRIES-1:0][RANK_W-1:0] touch(
    input logic [ENTRIES-1:0][RANK_W-1:0] r,
    input logic [RANK_W-1:0] idx
  );
    logic [ENTRIES-1:0][RANK_W-1:0] o;
    o = r;
    for (int i = 0; i < ENTRIES; i++) begin
      if (r[i] < r[idx]) o[i] = r[i] + 1'b1;
    end
    o[idx] = '0;
    return o;
  endfunction

  // Unloaded latency of the addressed backing memory
  always_comb begin
    logic [LAT_W-1:0] span;
    logic [LAT_W-1:0] extra;
    span = '0;
    extra = '0;
    unique case (region)
      REGION_NVS: begin
        lat = high_performance_operating_mode ? LAT_NVS_HP : LAT_NVS_LP; // RL12
      end
      REGION_SERIAL: begin
        span = high_performance_operating_mode ?
          LAT_SER_HP_MAX - LAT_SER_HP_MIN : LAT_SER_LP_MAX - LAT_SER_LP_MIN;
        extra = LAT_W'(multibit_serial_memory_port_cfg.turnaround) +
          LAT_W'(multibit_serial_memory_port_cfg.strobe_capture); // RL11
        if (extra > span) extra = span;
        // Data and fetches share the serial bus cost alike
        lat = (high_performance_operating_mode ? LAT_SER_HP_MIN :
          LAT_SER_LP_MIN) + extra +
          LAT_W'(multibit_serial_memory_port_cfg.bus_latency); // RL8 RL9 RL10
      end
      default: begin
        lat = high_performance_operating_mode ? LAT_XSRAM_HP :
          LAT_XSRAM_LP; // RL7
      end
    endcase
  end

  always_comb begin
    logic ev_free;
    logic ev_taken;
    logic any_dirty;
    logic done;
    logic [LINE_BITS-1:0] line;
    next_s = s;
    req_ready = 1'b0;
    ev_free = 1'b0;
    ev_taken = 1'b0;
    any_dirty = 1'b0;
    done = 1'b0;
    line = '0;
    next_s.rsp_valid = 1'b0;
    hit = |tag_hit;
    hidx = '0;
    vic = '0;
    for (int i = 0; i < ENTRIES; i++) begin
      if (tag_hit[i]) hidx = RANK_W'(i);
      if (s.rank[i] == RANK_W'(ENTRIES - 1)) vic = RANK_W'(i);
    end
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (!s.ent[i].valid) vic = RANK_W'(i); // RL1
    end
    word_ok = hit &&
      (&s.ent[hidx].bv[wsel*WORD_BYTES +: WORD_BYTES]);
    // Bus writes drain in the grant cycle, so the holding slot frees
    ev_free = !s.ev.valid || mem_gnt;
    if (s.ev.valid && mem_gnt) next_s.ev.valid = 1'b0;
    for (int i = 0; i < ENTRIES; i++) begin
      if (s.ent[i].dirty && s.ent[i].age != FLUSH_AGE) begin
        next_s.ent[i].age = s.ent[i].age + 1'b1;
      end
    end
    unique case (s.fsm)
      ST_IDLE: begin
        if (req.valid && req.write) begin
          if (hit || !s.ent[vic].dirty || ev_free) begin
            req_ready = 1'b1; // RL4 RL5
            if (!hit) begin
              if (s.ent[vic].dirty) begin
                next_s.ev = {1'b1, s.ent[vic].tag, s.ent[vic].bv,
                  s.ent[vic].data}; // RL3 RL14
                ev_taken = 1'b1;
              end
              next_s.ent[vic] = '0;
              next_s.ent[vic].valid = 1'b1;
              next_s.ent[vic].tag = req.addr[ADDR_W-1:LINE_LSB];
            end
            for (int k = 0; k < WORD_BYTES; k++) begin
              if (req.be[k]) begin
                next_s.ent[hit ? hidx : vic].data[(wsel*WORD_BYTES+k)*8 +: 8]
                  = req.wdata[k*8 +: 8]; // RL2
                next_s.ent[hit ? hidx : vic].bv[wsel*WORD_BYTES+k] = 1'b1;
              end
            end
            next_s.ent[hit ? hidx : vic].dirty = 1'b1;
            next_s.ent[hit ? hidx : vic].age = '0;
            next_s.rank = touch(s.rank, hit ? hidx : vic); // RL1
          end
        end else if (req.valid) begin
          if (word_ok) begin
            req_ready = 1'b1; // RL4
            next_s.rsp_valid = 1'b1;
            next_s.rsp_data = s.ent[hidx].data[wsel*WORD_W +: WORD_W]; // RL6
            next_s.rank = touch(s.rank, hidx);
          end else if (hit || !s.ent[vic].dirty || ev_free) begin
            req_ready = 1'b1;
            next_s.fsm = ST_FETCH; // RL13
            next_s.lat = lat;
            next_s.maddr = {req.addr[ADDR_W-1:WORD_LSB], WORD_LSB'(0)};
            next_s.midx = hit ? hidx : vic;
            if (!hit) begin
              if (s.ent[vic].dirty) begin
                next_s.ev = {1'b1, s.ent[vic].tag, s.ent[vic].bv,
                  s.ent[vic].data}; // RL14
                ev_taken = 1'b1;
              end
              next_s.ent[vic] = '0;
              next_s.ent[vic].valid = 1'b1;
              next_s.ent[vic].tag = req.addr[ADDR_W-1:LINE_LSB];
            end
          end
        end
      end
      ST_FETCH: begin
        // Reads wait behind pending write-back so memory stays ordered
        if (!s.ev.valid && mem_gnt) begin
          next_s.fsm = ST_WAIT; // RL15
          next_s.cnt = s.lat - LAT_PIPE;
          next_s.wcnt = LAT_W'(1);
        end
      end
      ST_WAIT: begin
        next_s.wcnt = s.wcnt + 1'b1;
        if (s.cnt == '0) begin
          for (int b = 0; b < LINE_BYTES; b++) begin
            line[b*8 +: 8] = s.ent[s.midx].bv[b] ?
              s.ent[s.midx].data[b*8 +: 8] : mem_rdata[b*8 +: 8];
          end
          next_s.ent[s.midx].data = line;
          next_s.ent[s.midx].bv = '1;
          next_s.rsp_valid = 1'b1;
          next_s.rsp_data =
            line[s.maddr[LINE_LSB-1:WORD_LSB]*WORD_W +: WORD_W]; // RL6
          next_s.rank = touch(s.rank, s.midx);
          next_s.fsm = ST_IDLE;
        end else begin
          next_s.cnt = s.cnt - 1'b1;
        end
      end
      default: next_s.fsm = ST_IDLE;
    endcase
    // Aged or commanded write-back; none is loaded while a fetch waits in ST_FETCH
    if (!ev_taken && ev_free && s.fsm != ST_FETCH) begin
      for (int i = 0; i < ENTRIES; i++) begin
        if (!done && next_s.ent[i].dirty &&
            (s.flush_pend || next_s.ent[i].age == FLUSH_AGE)) begin
          next_s.ev = {1'b1, next_s.ent[i].tag, next_s.ent[i].bv,
            next_s.ent[i].data}; // RL3
          next_s.ent[i].dirty = 1'b0;
          done = 1'b1;
        end
      end
    end
    for (int i = 0; i < ENTRIES; i++) begin
      any_dirty = any_dirty | next_s.ent[i].dirty;
    end
    next_s.flush_pend = flush_cmd ||
      (s.flush_pend && (any_dirty || next_s.ev.valid)); // RL3
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s <= '0;
      s.rank <= RANK_INIT;
    end else begin
      s <= next_s;
    end
  end

  assign rsp_valid = s.rsp_valid;
  assign rsp_data = s.rsp_data;
  assign flush_busy = s.flush_pend;
  assign mem_cmd.req = s.ev.valid || s.fsm == ST_FETCH;
  assign mem_cmd.write = s.ev.valid;
  assign mem_cmd.addr = s.ev.valid ? {s.ev.tag, LINE_LSB'(0)} : s.maddr;
  assign mem_cmd.wdata = s.ev.data;
  assign mem_cmd.be = s.ev.bv;

  a_write_zero_wait: assert property ( // RL4
    @(posedge ref_clk) disable iff (!rst_n)
    s.fsm == ST_IDLE && req.valid && req.write && (hit || !s.ent[vic].dirty)
    |-> req_ready)
    else $error("write with free slot stalled");
  a_stall_cause: assert property ( // RL5
    @(posedge ref_clk) disable iff (!rst_n)
    s.fsm == ST_IDLE && req.valid && req.write && !req_ready
    |-> s.ev.valid && !mem_gnt)
    else $error("write stalled without bus load");
  a_hit_next: assert property ( // RL6
    @(posedge ref_clk) disable iff (!rst_n)
    s.fsm == ST_IDLE && req.valid && !req.write && word_ok
    |=> rsp_valid)
    else $error("buffer hit not answered next cycle");
  a_sram_lat: assert property ( // RL7
    @(posedge ref_clk) disable iff (!rst_n)
    s.fsm == ST_IDLE && req.valid && !req.write && req_ready && !word_ok
    && region == REGION_XSRAM
    |=> s.lat == ($past(high_performance_operating_mode) ?
      LAT_XSRAM_HP : LAT_XSRAM_LP))
    else $error("extended SRAM miss latency wrong");
  a_serial_lat: assert property ( // RL8
    @(posedge ref_clk) disable iff (!rst_n)
    s.fsm == ST_IDLE && req.valid && req_ready && !word_ok && !req.write
    && region == REGION_SERIAL && !high_performance_operating_mode
    && multibit_serial_memory_port_cfg.bus_latency == 8'h00
    |=> s.lat >= LAT_SER_LP_MIN && s.lat <= LAT_SER_LP_MAX)
    else $error("serial miss latency out of range");
  a_nvs_lat: assert property ( // RL12
    @(posedge ref_clk) disable iff (!rst_n)
    s.fsm == ST_IDLE && req.valid && req_ready && !word_ok && !req.write
    && region == REGION_NVS && high_performance_operating_mode
    |=> s.lat == LAT_NVS_HP)
    else $error("nonvolatile miss latency wrong");
  a_miss_total: assert property ( // RL15
    @(posedge ref_clk) disable iff (!rst_n)
    s.fsm == ST_WAIT && s.cnt == '0 |-> s.wcnt == s.lat - 1'b1)
    else $error("miss latency counted wrong after grant");
  a_evict_hold: assert property ( // RL14
    @(posedge ref_clk) disable iff (!rst_n)
    s.fsm == ST_IDLE && req.valid && req_ready && !hit && !word_ok
    && s.ent[vic].dirty
    |=> s.ev.valid && s.ev.tag == $past(s.ent[vic].tag))
    else $error("dirty victim reused before write-back");
  a_fetch_order: assert property ( // RL13
    @(posedge ref_clk) disable iff (!rst_n)
    s.fsm == ST_IDLE && req.valid && !req.write && req_ready && !word_ok
    |=> s.fsm == ST_FETCH && mem_cmd.req &&
      s.maddr[ADDR_W-1:WORD_LSB] == $past(req.addr[ADDR_W-1:WORD_LSB]))
    else $error("line fetch not issued for the critical word");

endmodule // memory_line_buffer_latency

// file: tb/mem_model.sv
// System bus memory model answering line fetches and write-backs
`timescale 1ns/100ps
module mem_model import line_buffer_pkg::*; (
  // Clock
  input wire logic ref_clk,
  // Bus from the device
  input wire mem_cmd_t mem_cmd,
  output logic mem_gnt,
  output logic [LINE_BITS-1:0] mem_rdata,
  // Test control and observation
  input wire logic stall,
  output logic [ADDR_W-1:0] wb_addr,
  output logic [LINE_BITS-1:0] wb_data,
  output logic [LINE_BYTES-1:0] wb_be,
  output int wb_count
);
  logic [LINE_BITS-1:0] mem [logic [TAG_W-1:0]];
  logic [LINE_BITS-1:0] line;
  logic [TAG_W-1:0] t;

  function automatic logic [LINE_BITS-1:0] pat(logic [TAG_W-1:0] g);
    for (int w = 0; w < 4; w++) begin
      pat[w*32 +: 32] = ~{g, w[1:0], 2'h0};
    end
  endfunction

  // A stalled grant stands for competing bus traffic
  assign mem_gnt = !stall;

  initial begin
    wb_count = 0;
    mem_rdata = '1;
  end

  always @(posedge ref_clk) begin
    if (mem_cmd.req && mem_gnt) begin
      t = mem_cmd.addr[ADDR_W-1:LINE_LSB];
      line = mem.exists(t) ? mem[t] : pat(t);
      if (mem_cmd.write) begin
        for (int b = 0; b < LINE_BYTES; b++) begin
          if (mem_cmd.be[b]) line[b*8 +: 8] = mem_cmd.wdata[b*8 +: 8];
        end
        mem[t] = line;
        wb_addr <= mem_cmd.addr;
        wb_data <= mem_cmd.wdata;
        wb_be <= mem_cmd.be;
        wb_count <= wb_count + 1;
        // Read data is gone once the bus turns to a write
        mem_rdata <= ~mem_rdata;
      end else begin
        mem_rdata <= line;
      end
    end
  end
endmodule // mem_model

// file: tb/tb_top.sv
// Self-checking bench for the line buffer and its miss timing
`timescale 1ns/100ps
module tb_top import line_buffer_pkg::*;;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  cpu_req_t req = '0;
  logic req_ready, rsp_valid, flush_busy, mem_gnt;
  logic [WORD_W-1:0] rsp_data;
  logic hp = 1'b0;
  logic flush_cmd = 1'b0;
  logic stall = 1'b0;
  serial_cfg_t cfg = '0;
  mem_cmd_t mem_cmd;
  logic [LINE_BITS-1:0] mem_rdata, wb_data;
  logic [ADDR_W-1:0] wb_addr;
  logic [LINE_BYTES-1:0] wb_be;
  int wb_count, n_fail = 0, total_checks = 0, w, cyc, c0;
  logic [31:0] d;
  logic [31:0] la [7] = '{32'h1000_0104, 32'h1000_0208, 32'h0000_0304,
    32'h0000_0408, 32'h2000_050C, 32'h2000_0600, 32'h2000_0704};
  logic [LAT_W-1:0] ex [7] = '{LAT_XSRAM_LP, LAT_XSRAM_HP, LAT_NVS_LP,
    LAT_NVS_HP, LAT_SER_LP_MIN, LAT_SER_LP_MIN + 10'h009, LAT_SER_HP_MAX};
  serial_cfg_t sc [7] = '{'0, '0, '0, '0, '0, '{1'b1, 4'h3, 8'h05},
    '{1'b1, 4'hF, 8'h00}};
  logic hv [7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

  always #12.5 ref_clk = ~ref_clk;

  memory_line_buffer_latency #(.FLUSH_AGE(8'h20)) DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .high_performance_operating_mode(hp), .flush_cmd(flush_cmd),
    .flush_busy(flush_busy), .multibit_serial_memory_port_cfg(cfg),
    .mem_cmd(mem_cmd), .mem_gnt(mem_gnt), .mem_rdata(mem_rdata));

  mem_model partner (
    .ref_clk(ref_clk), .mem_cmd(mem_cmd), .mem_gnt(mem_gnt),
    .mem_rdata(mem_rdata), .stall(stall), .wb_addr(wb_addr),
    .wb_data(wb_data), .wb_be(wb_be), .wb_count(wb_count));

  function automatic logic [31:0] pw(logic [31:0] a);
    return ~{a[31:2], 2'h0};
  endfunction

  task automatic check(logic [127:0] seen, logic [127:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Request held until accepted; waits counts edges up to acceptance
  task automatic issue(logic wr, logic [31:0] a, logic [31:0] dt,
    logic [3:0] en, output int waits);
    @(negedge ref_clk);
    req = '{valid:1'b1, write:wr, instr:1'b0, addr:a, wdata:dt, be:en};
    waits = 0;
    do begin
      @(posedge ref_clk);
      waits++;
    end while (req_ready !== 1'b1 && waits < 300);
    @(negedge ref_clk);
    req.valid = 1'b0;
  endtask

  task automatic rd(logic [31:0] a, output logic [31:0] dt, output int n);
    int k;
    issue(1'b0, a, 32'h0, 4'h0, k);
    n = 1;
    while (rsp_valid !== 1'b1 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    dt = rsp_data;
  endtask

  task automatic results();
    $display("Checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #(25 * 6000);
    n_fail++;
    results();
  end

  initial begin
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 7; i++) begin
      hp = hv[i];
      cfg = sc[i];
      rd(la[i], d, cyc);
      check(cyc, ex[i] + 1);
      check(d, pw(la[i]));
    end
    rd(32'h2000_0708, d, cyc);
    check(cyc, 1);
    check(d, pw(32'h2000_0708));
    issue(1'b1, 32'h2000_0708, 32'h1234_5678, 4'hF, w);
    check(w, 1);
    rd(32'h2000_0708, d, cyc);
    check({cyc, d}, {32'd1, 32'h1234_5678});
    c0 = wb_count;
    @(negedge ref_clk);
    flush_cmd = 1'b1;
    @(negedge ref_clk);
    flush_cmd = 1'b0;
    check(flush_busy, 1'b1);
    w = 0;
    while (flush_busy !== 1'b0 && w < 100) begin
      @(negedge ref_clk);
      w++;
    end
    check(flush_busy, 1'b0);
    check(wb_count, c0 + 1);
    // The filled line goes out whole, merged word in place
    check({wb_addr, wb_be}, {32'h2000_0700, 16'hFFFF});
    check(wb_data[95:64], 32'h1234_5678);
    check(wb_data[63:32], pw(32'h2000_0704));
    // Five fresh lines through four entries: the oldest must leave first
    c0 = wb_count;
    for (int i = 0; i < 5; i++) begin
      issue(1'b1, 32'h1000_1000 + i * 16, 32'hA0 + i, 4'h1, w);
      check(w, 1);
    end
    repeat (3) @(negedge ref_clk);
    check(wb_count, c0 + 1);
    check({wb_addr, wb_be}, {32'h1000_1000, 16'h0001});
    check(wb_data[7:0], 8'hA0);
    repeat (80) @(negedge ref_clk);
    check(wb_count, c0 + 5);
    hp = 1'b0;
    stall = 1'b1;
    fork
      rd(32'h1000_2004, d, cyc);
      begin
        repeat (4) @(negedge ref_clk);
        stall = 1'b0;
      end
    join
    check(cyc, LAT_XSRAM_LP + 3);
    check(d, pw(32'h1000_2004));
    // Holding slot full and a dirty victim: the write waits for the bus
    c0 = wb_count;
    stall = 1'b1;
    for (int i = 0; i < 5; i++) begin
      issue(1'b1, 32'h1000_3000 + i * 16, 32'hB0 + i, 4'h1, w);
      check(w, 1);
    end
    fork
      issue(1'b1, 32'h1000_3050, 32'hC0, 4'h1, w);
      begin
        repeat (4) @(negedge ref_clk);
        stall = 1'b0;
      end
    join
    check(w, 4);
    @(negedge ref_clk);
    check(wb_count, c0 + 2);
    check({wb_addr, wb_data[7:0]}, {32'h1000_3010, 8'hB1});
    results();
  end
endmodule // tb_top
